// ===== dv/gal_host.sv
/* serial host model: one 16-bit word per frame, in and out.
   assumes ref_clk_i paces it; link clock rests low between frames. */
`timescale 1ns/1ps
`default_nettype none
module gal_host (
  input  wire logic ref_clk_i,
  input  wire logic ser_dout_i,
  output logic      ser_clk_o,
  output logic      ser_sel_n_o,
  output logic      ser_din_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_sel_n_o = 1'b1;
    ser_din_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge ref_clk_i);
    ser_sel_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ser_clk_o <= 1'b0;
      ser_din_o <= w[i];
      // long low phase: output shifts a few clocks after the fall
      repeat (4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      r[i] = ser_dout_i;
      @(posedge ref_clk_i);
      ser_clk_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
    end
    // park the clock low inside the frame so it rests low between frames
    ser_clk_o <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    ser_sel_n_o <= 1'b1;
    ser_din_o <= ~ser_din_o;
    repeat (8) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ===== dv/gal_monitor.sv
/* port checker for gal_top.
   assumes one ref_clk_i domain; bound to gal_top below. */
`timescale 1ns/1ps
`default_nettype none
module gal_monitor (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        ser_sel_n_i,
  input wire logic [3:0]  pin_oe_o,
  input wire logic [2:0]  aux_analog_sel_o,
  input wire logic [3:0]  lim_hi_evt_i,
  input wire logic [3:0]  lim_lo_evt_i,
  input wire logic [11:0] alert_reg_o,
  input wire logic        alarm_n_o
);
  wire [11:0] ar = alert_reg_o;
  wire [7:0]  ev = {lim_lo_evt_i, lim_hi_evt_i};
  wire [3:0]  act = (ar[3:0] | ar[7:4]) & ar[11:8];
  // a pin can only raise the alarm while neither driven nor analog
  wire        src = |act || |(~pin_oe_o & {1'b1, ~aux_analog_sel_o});
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  rst_alarm_a:
    assert property ($rose(reset_n_i) |-> alarm_n_o) else $error("reset alarm");
  flag_set_a:
    assert property (|ev |=> &(ar[7:0] | ~$past(ev))) else $error("flag lost");
  flag_src_a:
    assert property ((ar[7:0] & ~$past(ar[7:0]) & ~$past(ev)) == 8'h00)
      else $error("flag no event");
  flag_clr_a:
    assert property (|($past(ar[7:0]) & ~ar[7:0]) |-> !$past(ser_sel_n_i))
      else $error("flag clear idle");
  lim_alarm_a:
    assert property (|act |=> !alarm_n_o) else $error("alarm missed");
  alarm_src_a:
    assert property (!alarm_n_o |-> $past(src)) else $error("alarm no source");
  analog_oe_a:
    assert property ((pin_oe_o[2:0] & aux_analog_sel_o) == 3'h0)
      else $error("analog driven");
  cfg_frame_a:
    assert property (!$stable(pin_oe_o) || !$stable(ar[11:8])
      |-> !$past(ser_sel_n_i)) else $error("config idle change");
  cover property ($fell(alarm_n_o));
  cover property (|act);
  cover property (|pin_oe_o[2:0]);
endmodule
bind gal_top gal_monitor i_mon (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
  .ser_sel_n_i(ser_sel_n_i), .pin_oe_o(pin_oe_o),
  .aux_analog_sel_o(aux_analog_sel_o), .lim_hi_evt_i(lim_hi_evt_i),
  .lim_lo_evt_i(lim_lo_evt_i), .alert_reg_o(alert_reg_o),
  .alarm_n_o(alarm_n_o));
`default_nettype wire

// ===== dv/gal_top_bench.sv
/* self-checking bench for gal_top.
   assumes gal_host as serial master and gal_monitor bound in. */
`timescale 1ns/1ps
`default_nettype none
module gal_top_bench;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        ser_clk_i;
  logic        ser_sel_n_i;
  logic        ser_din_i;
  logic        ser_dout_o;
  logic        alarm_n_o;
  logic [3:0]  ext = 4'h0;
  logic [3:0]  hi = 4'h0;
  logic [3:0]  lo = 4'h0;
  logic [3:0]  pin_o;
  logic [3:0]  pin_oe_o;
  logic [2:0]  aux_analog_sel_o;
  logic [11:0] alert_reg_o;
  logic [15:0] r;
  int          err_total = 0;
  int          tests_run = 0;
  wire  [3:0]  pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext);
  gal_top i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .ser_clk_i(ser_clk_i), .ser_sel_n_i(ser_sel_n_i), .ser_din_i(ser_din_i),
    .ser_dout_o(ser_dout_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .aux_analog_sel_o(aux_analog_sel_o),
    .lim_hi_evt_i(hi), .lim_lo_evt_i(lo), .alert_reg_o(alert_reg_o),
    .alarm_n_o(alarm_n_o));
  gal_host i_host (.ref_clk_i(ref_clk_i), .ser_dout_i(ser_dout_o),
    .ser_clk_o(ser_clk_i), .ser_sel_n_o(ser_sel_n_i), .ser_din_o(ser_din_i));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("run %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic ew(input logic [3:0] a, input logic [7:0] d);
    i_host.xfer({4'hF, a, d}, r);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    i_host.xfer({5'h02, a, 6'h00}, r);
    i_host.xfer(16'h0000, r);
    chk(r, e);
  endtask
  task automatic wt(input logic e);
    int n = 0;
    @(negedge ref_clk_i);
    while (alarm_n_o !== e && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk({15'h0000, alarm_n_o}, {15'h0000, e});
    if (alarm_n_o !== e) conclude();
  endtask
  task automatic t_rst();
    @(negedge ref_clk_i);
    chk({3'h0, pin_oe_o, pin_o, ser_dout_o, aux_analog_sel_o, alarm_n_o},
      16'h11EF);
    chk({4'h0, alert_reg_o}, 16'h0000);
    rd(5'h1D, 16'h0000);
    $display("test rst done");
  endtask
  task automatic t_out();
    ew(4'h0, 8'h8B);
    ew(4'h1, 8'h20);
    ew(4'h2, 8'h0B);
    @(negedge ref_clk_i);
    chk({5'h00, pin_oe_o, pin_o[3], pin_o[1:0], aux_analog_sel_o, alarm_n_o},
      16'h05D9);
    rd(5'h1B, 16'h008B);
    i_host.xfer(16'h0000, r);
    chk(r, 16'h0020);
    i_host.xfer(16'h0000, r);
    chk(r, 16'h000B);
    $display("test out done");
  endtask
  task automatic t_in();
    @(posedge ref_clk_i) ext[2] <= 1'b1;
    ew(4'h1, 8'h2D);
    wt(1'b1);
    @(posedge ref_clk_i) ext[2] <= 1'b0;
    wt(1'b0);
    ew(4'h2, 8'h0B);
    rd(5'h1D, 16'h000F);
    @(posedge ref_clk_i) ext[2] <= 1'b1;
    wt(1'b1);
    @(posedge ref_clk_i) ext[2] <= 1'b0;
    wt(1'b0);
    ew(4'h1, 8'h2C);
    wt(1'b1);
    ew(4'h1, 8'h2F);
    wt(1'b1);
    @(posedge ref_clk_i) ext[2] <= 1'b1;
    wt(1'b0);
    ew(4'h1, 8'h27);
    wt(1'b1);
    $display("test in done");
  endtask
  task automatic t_lim();
    @(negedge ref_clk_i);
    chk({4'h0, alert_reg_o}, 16'h0000);
    i_host.xfer({4'h3, 4'hF, 8'hFF}, r);
    @(posedge ref_clk_i) hi <= 4'h2;
    @(posedge ref_clk_i) hi <= 4'h0;
    wt(1'b0);
    rd(5'h03, 16'h0F02);
    i_host.xfer({4'h3, 4'hF, 8'hFD}, r);
    wt(1'b1);
    i_host.xfer({4'h3, 4'h0, 8'hFF}, r);
    @(posedge ref_clk_i) lo <= 4'h8;
    @(posedge ref_clk_i) lo <= 4'h0;
    repeat (4) @(negedge ref_clk_i);
    chk({3'h0, alarm_n_o, alert_reg_o}, 16'h1080);
    i_host.xfer({4'h3, 4'h8, 8'hFF}, r);
    wt(1'b0);
    $display("test lim done");
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_rst();
    t_out();
    t_in();
    t_lim();
    conclude();
  end
endmodule
`default_nettype wire

// ===== verilog/gal_defs.vh
/*
 * constants for the pin and alarm block: register addresses, field
 * positions, reset values and serial framing.
 * assumes inclusion by bare name from the design files of this block.
 */
`ifndef GAL_DEFS_VH
`define GAL_DEFS_VH

// ************************************************************
// serial framing
// ************************************************************
`define GAL_WORD_BITS      5'h10
`define GAL_BITCNT_W       5
`define GAL_EXT_WADDR      4'hF
`define GAL_ALERT_WADDR    4'h3
`define GAL_CTRL1_WADDR    4'h1

// ************************************************************
// extended write map
// ************************************************************
`define GAL_EADDR_CFG_LO   4'h0
`define GAL_EADDR_CFG_HI   4'h1
`define GAL_EADDR_DATA     4'h2

// ************************************************************
// read map (5-bit read addresses)
// ************************************************************
`define GAL_RADDR_ALERT    5'h03
`define GAL_RADDR_CFG_LO   5'h1B
`define GAL_RADDR_CFG_HI   5'h1C
`define GAL_RADDR_DATA     5'h1D
`define GAL_RADDR_WRAP     5'h1F
`define GAL_RADDR_LSB      6
`define GAL_RADDR_MSB      10

// ************************************************************
// per-pin config nibble: function, direction, polarity, alarm
// ************************************************************
`define GAL_CFG_FUNC       3
`define GAL_CFG_DIR        2
`define GAL_CFG_POL        1
`define GAL_CFG_IRQ        0

// ************************************************************
// limit status/enable layout: high flags [3:0], low [7:4], en [11:8]
// channel order: aux, battery one, battery two, thermal
// ************************************************************
`define GAL_LIM_HI_LSB     0
`define GAL_LIM_LO_LSB     4
`define GAL_LIM_EN_LSB     8

// ************************************************************
// reset values
// ************************************************************
`define GAL_CFG_RST        8'h00
`define GAL_DATA_RST       8'h00
`define GAL_LIM_RST        12'h000
`define GAL_RADDR_RST      5'h00

`endif

// ===== verilog/gal_pin.v
/*
 * one pin slice: turns its config nibble and data bit into pad drive,
 * input-captured data and an alarm request.
 * assumes pad_i is already synchronised to ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gal_defs.vh"

module gal_pin #(
  parameter FIXED = 0
) (
  input  wire [3:0] cfg_i,
  input  wire       data_i,
  input  wire       pad_i,
  output wire       gpio_on_o,
  output wire       is_input_o,
  output wire       in_data_o,
  output wire       pad_o,
  output wire       pad_oe_o,
  output wire       alarm_o
);

  assign gpio_on_o  = (FIXED != 0) ? 1'b1 : cfg_i[`GAL_CFG_FUNC];
  assign is_input_o = gpio_on_o & cfg_i[`GAL_CFG_DIR];
  assign in_data_o  = cfg_i[`GAL_CFG_POL] ? pad_i : ~pad_i;
  assign pad_oe_o   = gpio_on_o & ~cfg_i[`GAL_CFG_DIR];
  assign pad_o      = cfg_i[`GAL_CFG_POL] ? data_i : ~data_i;
  assign alarm_o    = is_input_o & cfg_i[`GAL_CFG_IRQ] & data_i;

endmodule
`default_nettype wire

// ===== verilog/gal_sync.v
/*
 * two-flop synchroniser, one bit per lane.
 * assumes inputs come from outside the ref_clk_i domain.
 */
`timescale 1ns/1ps
`default_nettype none

module gal_sync #(
  parameter W = 1
) (
  input  wire         ref_clk_i,
  input  wire         reset_n_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // first stage feeds only the second
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule
`default_nettype wire

// ===== verilog/gal_top.v
/*
 * pin configuration, pin data and limit alarm logic of a touch screen
 * controller, with the serial register port that reaches them.
 * assumes a 100 MHz ref_clk_i far faster than the serial clock, which
 * is sampled and edge-detected here; limit flags arrive as one-cycle
 * pulses from the comparators on the same clock.
 */
// Contract
// - top nibble 1111b means extended write
// - extended: configs at 0,1, data at 2
// - readable at read addresses 11011b..11101b
// - four config bits, one data bit
// - function bit zero leaves pin analog
// - fixed pin always general purpose
// - output pin driven from data bit
// - input pin: data follows pad, read-only
// - input data equals pad if active-high
// - output equals data if active-high
// - irq-allow zero blocks pin alarm
// - enabled input data set asserts alarm
// - limit events set high/low status bits
// - per-channel enable masks limit flags
// - alarm low while any unmasked source
// - pin alarm released by mask or level
// - write zero clears; an event in the same cycle wins
// - host writes 16-bit word, chip select low
// - 8-bit reads padded with eight zeros
`timescale 1ns/1ps
`default_nettype none
`include "gal_defs.vh"

module gal_top (
  input  wire        ref_clk_i,
  input  wire        reset_n_i,
  input  wire        ser_clk_i,
  input  wire        ser_sel_n_i,
  input  wire        ser_din_i,
  output wire        ser_dout_o,
  input  wire [3:0]  pin_i,
  output wire [3:0]  pin_o,
  output wire [3:0]  pin_oe_o,
  output wire [2:0]  aux_analog_sel_o,
  input  wire [3:0]  lim_hi_evt_i,
  input  wire [3:0]  lim_lo_evt_i,
  output wire [11:0] alert_reg_o,
  output wire        alarm_n_o
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  wire [6:0] sync_w;
  wire [3:0] pin_s;
  wire       sclk_s;
  wire       ssel_n_s;
  wire       sdin_s;

  gal_sync #(
    .W (7)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({pin_i, ser_clk_i, ~ser_sel_n_i, ser_din_i}),
    .sync_o    (sync_w)
  );

  assign pin_s    = sync_w[6:3];
  assign sclk_s   = sync_w[2];
  // select travels inverted, so the flops' reset value reads as idle
  // and no false select edge follows reset
  assign ssel_n_s = ~sync_w[1];
  assign sdin_s   = sync_w[0];

  // ************************************************************
  // serial clock edges
  // ************************************************************
  reg sclk_d_r;
  reg ssel_d_r;

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      sclk_d_r <= 1'b0;
      ssel_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      ssel_d_r <= ssel_n_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire sel_fall  = ~ssel_n_s & ssel_d_r;
  wire sel_rise  = ssel_n_s & ~ssel_d_r;

  // ************************************************************
  // registers
  // ************************************************************
  reg [7:0]  cfg_lo_r;
  reg [7:0]  cfg_hi_r;
  reg [7:0]  data_r;
  reg [7:0]  data_nxt;
  reg [11:0] lim_r;
  reg [11:0] lim_nxt;
  reg [4:0]  raddr_r;
  reg [15:0] sh_in_r;
  reg [4:0]  bitcnt_r;
  reg [15:0] sh_out_r;
  reg        alarm_n_r;
  reg        frame_done_r;
  reg        raddr_hold_r;

  // ************************************************************
  // pin slices
  // ************************************************************
  wire [15:0] cfg_all = {cfg_hi_r, cfg_lo_r};
  wire [3:0]  gpio_on;
  wire [3:0]  is_input;
  wire [3:0]  in_data;
  wire [3:0]  pin_alarm;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      gal_pin #(
        .FIXED ((g == 3) ? 1 : 0)
      ) u_pin (
        .cfg_i      (cfg_all[4*g+3:4*g]),
        .data_i     (data_r[g]),
        .pad_i      (pin_s[g]),
        .gpio_on_o  (gpio_on[g]),
        .is_input_o (is_input[g]),
        .in_data_o  (in_data[g]),
        .pad_o      (pin_o[g]),
        .pad_oe_o   (pin_oe_o[g]),
        .alarm_o    (pin_alarm[g])
      );
    end
  endgenerate

  assign aux_analog_sel_o = ~gpio_on[2:0];

  // ************************************************************
  // write decode
  // ************************************************************
  // word completes on the 16th rising serial edge
  wire [15:0] word_w   = {sh_in_r[14:0], sdin_s};
  // bits past the sixteenth are dropped until select rises again
  wire        word_end = ~ssel_n_s & sclk_rise & ~frame_done_r &
                         (bitcnt_r == (`GAL_WORD_BITS - 5'h01));
  wire        ext_wr   = word_end & (word_w[15:12] == `GAL_EXT_WADDR);
  wire        wr_cfg_lo = ext_wr & (word_w[11:8] == `GAL_EADDR_CFG_LO);
  wire        wr_cfg_hi = ext_wr & (word_w[11:8] == `GAL_EADDR_CFG_HI);
  wire        wr_data   = ext_wr & (word_w[11:8] == `GAL_EADDR_DATA);
  wire        wr_lim    = word_end & (word_w[15:12] == `GAL_ALERT_WADDR);
  wire        wr_ctrl1  = word_end & (word_w[15:12] == `GAL_CTRL1_WADDR);

  // ************************************************************
  // pin data register
  // ************************************************************
  // input bits resample every clock, so a host write to them is lost
  integer i;
  always @* begin
    data_nxt = data_r;
    for (i = 0; i < 4; i = i + 1) begin
      if (is_input[i]) begin
        // input bit follows pad, host write ignored
        data_nxt[i] = in_data[i];
      end else if (wr_data) begin
        data_nxt[i] = word_w[i];
      end
    end
    if (wr_data) begin
      data_nxt[7:4] = word_w[7:4];
    end
  end

  // ************************************************************
  // limit status flags
  // ************************************************************
  always @* begin
    lim_nxt = lim_r;
    if (wr_lim) begin
      lim_nxt[7:0] = lim_r[7:0] & word_w[7:0];
      lim_nxt[11:8] = word_w[11:8];
    end
    // event sets flag, wins over clear
    lim_nxt[`GAL_LIM_HI_LSB+3:`GAL_LIM_HI_LSB] =
      lim_nxt[`GAL_LIM_HI_LSB+3:`GAL_LIM_HI_LSB] | lim_hi_evt_i;
    lim_nxt[`GAL_LIM_LO_LSB+3:`GAL_LIM_LO_LSB] =
      lim_nxt[`GAL_LIM_LO_LSB+3:`GAL_LIM_LO_LSB] | lim_lo_evt_i;
  end

  // ************************************************************
  // register update
  // ************************************************************
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cfg_lo_r <= `GAL_CFG_RST;
      cfg_hi_r <= `GAL_CFG_RST;
      data_r   <= `GAL_DATA_RST;
      lim_r    <= `GAL_LIM_RST;
    end else begin
      if (wr_cfg_lo) begin
        cfg_lo_r <= word_w[7:0];
      end
      if (wr_cfg_hi) begin
        cfg_hi_r <= word_w[7:0];
      end
      data_r <= data_nxt;
      lim_r  <= lim_nxt;
    end
  end

  // ************************************************************
  // serial shifter
  // ************************************************************
  reg [15:0] rd_word;
  always @* begin
    case (raddr_r)
      `GAL_RADDR_CFG_LO: rd_word = {8'h00, cfg_lo_r};
      `GAL_RADDR_CFG_HI: rd_word = {8'h00, cfg_hi_r};
      `GAL_RADDR_DATA:   rd_word = {8'h00, data_r};
      `GAL_RADDR_ALERT:  rd_word = {4'h0, lim_r};
      default:           rd_word = 16'h0000;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      sh_in_r      <= 16'h0000;
      bitcnt_r     <= 5'h00;
      frame_done_r <= 1'b0;
      sh_out_r     <= 16'h0000;
    end else begin
      if (ssel_n_s) begin
        bitcnt_r     <= 5'h00;
        frame_done_r <= 1'b0;
      end else if (sclk_rise & ~frame_done_r) begin
        sh_in_r      <= word_w;
        bitcnt_r     <= word_end ? 5'h00 : bitcnt_r + 5'h01;
        frame_done_r <= word_end;
      end
      if (sel_fall) begin
        sh_out_r <= rd_word;
      end else if (sclk_fall & ~ssel_n_s) begin
        sh_out_r <= {sh_out_r[14:0], 1'b0};
      end
    end
  end

  // ************************************************************
  // read address
  // ************************************************************
  // address advances after a read frame, wrapping at 11111b; a frame
  // that loads it must not also step it, or the next read is one off
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      raddr_r      <= `GAL_RADDR_RST;
      raddr_hold_r <= 1'b0;
    end else begin
      if (wr_ctrl1) begin
        raddr_r      <= word_w[`GAL_RADDR_MSB:`GAL_RADDR_LSB];
        raddr_hold_r <= 1'b1;
      end else if (sel_rise) begin
        raddr_hold_r <= 1'b0;
        if (!raddr_hold_r) begin
          raddr_r <= (raddr_r == `GAL_RADDR_WRAP) ? 5'h00
                                                  : raddr_r + 5'h01;
        end
      end
    end
  end

  assign ser_dout_o = sh_out_r[15];

  // ************************************************************
  // alarm
  // ************************************************************
  // per-channel enable mask
  wire [3:0] lim_en  = lim_r[`GAL_LIM_EN_LSB+3:`GAL_LIM_EN_LSB];
  wire [3:0] lim_act = lim_en &
    (lim_r[`GAL_LIM_HI_LSB+3:`GAL_LIM_HI_LSB] |
     lim_r[`GAL_LIM_LO_LSB+3:`GAL_LIM_LO_LSB]);

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      alarm_n_r <= 1'b1;
    end else begin
      // pins arrive two sync flops plus one data cycle late
      // level OR, registered
      alarm_n_r <= ~(|lim_act | |pin_alarm);
    end
  end

  assign alarm_n_o   = alarm_n_r;
  assign alert_reg_o = lim_r;

endmodule
`default_nettype wire
